// file: hw/meter_consts.svh
// constants for the telemetry packet transmitter
// assumes a 25 MHz system clock and the meter_pkg types
// ----------------------------------------
// Summary of operation
// ----------------------------------------
`ifndef METER_CONSTS_SVH
`define METER_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 25000000
`define BAUD_RATE 4800
`define BIT_CYCLES ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define US_CYCLES (`CLK_HZ / 1000000)
`define SAMPLE_DIV 4
`define WORD_DIV 128
`define HPF_SHIFT 13
// ----------------------------------------
// packet layout
// ----------------------------------------
`define PKT_BYTES 24
`define HDR_UNCAL 8'hAA
`define HDR_CAL 8'h55
`define HDR_ABN 4'hF
`define HDR_TWO 8'h5A
`define COEF_UNCAL 8'hFF
`define IDX_HDR1 5'h00
`define IDX_HDR2 5'h01
`define IDX_FLAG 5'h14
`define IDX_CNT_HI 5'h15
`define IDX_CNT_LO 5'h16
`define IDX_TAIL 5'h17
`define CHAR_BITS 11
`endif

// file: hw/meter_packet_tx.sv
// packet framer, pulse output and rate dividers of the meter
// assumes measurement words arrive as steady levels from the dsp core
`timescale 1ns/10ps
`default_nettype none
`include "meter_consts.svh"
module meter_packet_tx #(
	parameter int BIT_CYCLES = `BIT_CYCLES,
	parameter int GAP_BYTES = 2,
	// energy accumulator width; below 37 a full-scale product can wrap unseen
	parameter int ACC_BITS = 48
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic serial_rx_in,
	input wire logic calibrated,
	input wire meter_pkg::fault_type faults,
	input wire meter_pkg::meas_type meas,
	input wire logic [15:0] chan_v1,
	input wire logic [15:0] chan_v2,
	input wire logic [7:0] pulse_half_period,
	output logic serial_tx_out,
	output logic energy_pulse_out,
	output logic modulator_sample_clk,
	output logic filter_word_rate,
	output logic [15:0] chan_v1_hp,
	output logic [15:0] chan_v2_hp,
	output logic [15:0] pulse_count
);
	// receive pin unused: no logic reads it
	wire unused_rx = serial_rx_in;
	// ----------------------------------------
	// rate dividers
	// ----------------------------------------
	logic [6:0] div_q;
	logic [$clog2(BIT_CYCLES)-1:0] baud_q;
	logic baud_en;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) div_q <= 7'h00;
		else div_q <= div_q + 7'h01;
	end
	// square sample clock at clk/4
	assign modulator_sample_clk = div_q[1];
	wire word_tick = div_q == 7'(`WORD_DIV - 1);
	assign filter_word_rate = word_tick;
	// rounding keeps baud error far below two percent
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) baud_q <= '0;
		else if (baud_en) baud_q <= '0;
		else baud_q <= baud_q + ($clog2(BIT_CYCLES))'(1);
	end
	assign baud_en = baud_q == ($clog2(BIT_CYCLES))'(BIT_CYCLES - 1);
	// ----------------------------------------
	// offset removal
	// ----------------------------------------
	// single-pole high pass updated at word rate; shift sets the corner
	function automatic logic [31:0] hp_step(input logic [31:0] acc, input logic [15:0] x);
		logic [31:0] ext;
		logic signed [31:0] step;
		ext = {{16{x[15]}}, x} <<< `HPF_SHIFT;
		// signed step, so the estimate can also move downwards
		step = $signed(ext - acc) >>> `HPF_SHIFT;
		hp_step = acc + step;
	endfunction : hp_step
	logic [31:0] dc1_q, dc2_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dc1_q <= 32'h0;
			dc2_q <= 32'h0;
		end else if (word_tick) begin
			dc1_q <= hp_step(dc1_q, chan_v1);
			dc2_q <= hp_step(dc2_q, chan_v2);
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chan_v1_hp <= 16'h0;
			chan_v2_hp <= 16'h0;
		end else if (word_tick) begin
			chan_v1_hp <= chan_v1 - dc1_q[`HPF_SHIFT +: 16];
			chan_v2_hp <= chan_v2 - dc2_q[`HPF_SHIFT +: 16];
		end
	end
	// ----------------------------------------
	// energy pulse
	// ----------------------------------------
	// product times 48 accumulated each word tick; fosc/128 is the word rate
	wire [31:0] prod = $signed(chan_v1_hp) * $signed(chan_v2_hp);
	// magnitude only: a negative product must not look like a huge positive one
	wire [31:0] prod_mag = prod[31] ? 32'h0 - prod : prod;
	wire [37:0] prod48 = {6'h0, prod_mag} * 38'd48;
	logic [ACC_BITS-1:0] energy_q;
	logic pulse_q;
	logic [7:0] half_q;
	logic [15:0] count_q;
	wire energy_wrap = energy_q[ACC_BITS-1] && !prod48[37];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) energy_q <= '0;
		else if (word_tick) energy_q <= {1'b0, energy_q[ACC_BITS-2:0]} + ACC_BITS'(prod48);
	end
	// an overflow of the accumulator sets one pending flag, which starts a pulse of fixed high and low halves; overflows while it is set merge
	logic pend_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_q <= 1'b0;
			half_q <= 8'h0;
			pend_q <= 1'b0;
			count_q <= 16'h0;
		end else begin
			if (word_tick && energy_q[ACC_BITS-1]) pend_q <= 1'b1;
			if (word_tick && half_q != 8'h0) half_q <= half_q - 8'h1;
			if (word_tick && half_q == 8'h0) begin
				if (pulse_q) begin
					pulse_q <= 1'b0;
					half_q <= pulse_half_period;
				end else if (pend_q) begin
					pulse_q <= 1'b1;
					half_q <= pulse_half_period;
					// an overflow in the same tick is kept, not lost
					pend_q <= energy_q[ACC_BITS-1];
					count_q <= count_q + 16'h1;
				end
			end
		end
	end
	assign energy_pulse_out = pulse_q;
	assign pulse_count = count_q;
	wire unused_wrap = energy_wrap;
	// ----------------------------------------
	// packet assembly
	// ----------------------------------------
	meter_pkg::tx_state_type state_q;
	logic [4:0] idx_q;
	logic [7:0] sum_q;
	logic [7:0] byte_q;
	logic [7:0] gap_q;
	logic start_q;
	logic char_busy;
	// snapshot keeps one packet coherent while measurements move
	meter_pkg::meas_type snap_q;
	logic [15:0] cnt_snap_q;
	logic cal_snap_q;
	meter_pkg::fault_type flt_snap_q;
	wire any_fault = |flt_snap_q;
	wire [7:0] hdr1 = any_fault ? {`HDR_ABN, flt_snap_q} :
		(cal_snap_q ? `HDR_CAL : `HDR_UNCAL);
	wire [7:0] coef_byte_sel;
	function automatic logic [7:0] pick3(input logic [23:0] w, input logic [1:0] k);
		pick3 = (k == 2'd0) ? w[23:16] : (k == 2'd1) ? w[15:8] : w[7:0];
	endfunction : pick3
	wire [4:0] fld = idx_q - 5'd2;
	wire [2:0] fsel = 3'(fld / 5'd3);
	wire [1:0] fpos = 2'(fld % 5'd3);
	wire is_coef = !fsel[0];
	// cycle fields are passed in microseconds as measured
	wire [23:0] field = (fsel == 3'd0) ? snap_q.volt_coef : (fsel == 3'd1) ? snap_q.volt_cycle :
		(fsel == 3'd2) ? snap_q.curr_coef : (fsel == 3'd3) ? snap_q.curr_cycle :
		(fsel == 3'd4) ? snap_q.pwr_coef : snap_q.pwr_cycle;
	assign coef_byte_sel = (is_coef && !cal_snap_q) ? `COEF_UNCAL : pick3(field, fpos);
	wire [7:0] next_byte = (idx_q == `IDX_HDR1) ? hdr1 :
		(idx_q == `IDX_HDR2) ? `HDR_TWO :
		(idx_q == `IDX_FLAG) ? snap_q.flag :
		(idx_q == `IDX_CNT_HI) ? cnt_snap_q[15:8] :
		(idx_q == `IDX_CNT_LO) ? cnt_snap_q[7:0] :
		(idx_q == `IDX_TAIL) ? sum_q : coef_byte_sel;
	wire sums = idx_q != `IDX_HDR1 && idx_q != `IDX_HDR2 && idx_q != `IDX_TAIL;
	meter_pkg::tx_state_type state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			meter_pkg::TX_IDLE: if (gap_q == 8'h0) state_d = meter_pkg::TX_LOAD;
			meter_pkg::TX_LOAD: if (!char_busy) state_d = meter_pkg::TX_SHIFT;
			meter_pkg::TX_SHIFT: if (char_busy) state_d = (idx_q == `IDX_TAIL) ? meter_pkg::TX_IDLE : meter_pkg::TX_LOAD;
			default: state_d = meter_pkg::TX_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= meter_pkg::TX_IDLE;
			idx_q <= 5'h0;
			sum_q <= 8'h0;
			byte_q <= 8'h0;
			start_q <= 1'b0;
			gap_q <= 8'(GAP_BYTES * `CHAR_BITS);
			snap_q <= '0;
			cnt_snap_q <= 16'h0;
			cal_snap_q <= 1'b0;
			flt_snap_q <= '0;
		end else begin
			state_q <= state_d;
			start_q <= 1'b0;
			case (state_q)
				meter_pkg::TX_IDLE: begin
					if (baud_en && gap_q != 8'h0) gap_q <= gap_q - 8'h1;
					if (gap_q == 8'h0) begin
						snap_q <= meas;
						cnt_snap_q <= count_q;
						cal_snap_q <= calibrated;
						flt_snap_q <= faults;
						idx_q <= 5'h0;
						sum_q <= 8'h0;
					end
				end
				meter_pkg::TX_LOAD: if (!char_busy) begin
					byte_q <= next_byte;
					start_q <= 1'b1;
					if (sums) sum_q <= sum_q + next_byte;
				end
				meter_pkg::TX_SHIFT: if (char_busy) begin
					if (idx_q == `IDX_TAIL) gap_q <= 8'(GAP_BYTES * `CHAR_BITS);
					else idx_q <= idx_q + 5'h1;
				end
				default: ;
			endcase
		end
	end
	uart_char_tx char_tx (
		.clk(clk),
		.nrst(nrst),
		.baud_en(baud_en),
		.start(start_q),
		.data(byte_q),
		.busy(char_busy),
		.line_out(serial_tx_out)
	);
endmodule : meter_packet_tx
`default_nettype wire

// file: hw/meter_pkg.sv
// types shared by the packet transmitter
// assumes meter_consts.svh is compiled alongside
`default_nettype none
package meter_pkg;
	typedef struct packed {
		logic [23:0] volt_coef;
		logic [23:0] volt_cycle;
		logic [23:0] curr_coef;
		logic [23:0] curr_cycle;
		logic [23:0] pwr_coef;
		logic [23:0] pwr_cycle;
		logic [7:0] flag;
	} meas_type;
	typedef struct packed {
		logic volt_range;
		logic curr_range;
		logic pwr_range;
		logic coef_bad;
	} fault_type;
	typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} tx_state_type;
endpackage : meter_pkg
`default_nettype wire

// file: hw/uart_char_tx.sv
// one serial character: start, 8 data lsb first, even parity, stop
// assumes a one-cycle baud enable from the parent
`timescale 1ns/10ps
`default_nettype none
`include "meter_consts.svh"
module uart_char_tx (
	input wire logic clk,
	input wire logic nrst,
	input wire logic baud_en,
	input wire logic start,
	input wire logic [7:0] data,
	output logic busy,
	output logic line_out
);
	logic [10:0] shift_q;
	logic [3:0] left_q;
	wire parity = ^data;
	// ----------------------------------------
	// shifter
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shift_q <= 11'h7FF;
			left_q <= 4'h0;
		end else if (start && left_q == 4'h0) begin
			shift_q <= {1'b1, parity, data, 1'b0};
			left_q <= 4'(`CHAR_BITS);
		end else if (baud_en && left_q != 4'h0) begin
			shift_q <= {1'b1, shift_q[10:1]};
			left_q <= left_q - 4'h1;
		end
	end
	assign busy = left_q != 4'h0;
	// start bit appears at the first baud enable after loading
	logic out_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) out_q <= 1'b1;
		else if (baud_en) out_q <= (left_q != 4'h0) ? shift_q[0] : 1'b1;
	end
	assign line_out = out_q;
endmodule : uart_char_tx
`default_nettype wire

// file: test/host_uart_rx.sv
// host receiver model for the telemetry line
// assumes an idle-high line and clk-based bit timing
`timescale 1ns/10ps
`default_nettype none
module host_uart_rx #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic line,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_err
);
	// ----
	// sampler
	// ----
	logic [9:0] sh;
	logic lost;
	// negedge sampling keeps clear of the line's launch edge
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		rx_err = 1'b0;
		forever begin
			@(negedge clk);
			rx_valid = 1'b0;
			if (nrst === 1'b1 && line === 1'b0) begin
				repeat (BIT_CYCLES / 2) @(negedge clk);
				rx_err = line !== 1'b0;
				lost = 1'b0;
				for (int i = 0; i < 10; i++) begin
					repeat (BIT_CYCLES) @(negedge clk);
					sh[i] = line;
					lost = lost | (nrst !== 1'b1);
				end
				rx_err = rx_err | ^sh[8:0] | !sh[9];
				rx_byte = sh[7:0];
				rx_valid = !lost;
			end
		end
	end
endmodule : host_uart_rx
`default_nettype wire

// file: test/meter_packet_tx_chk.sv
// port checker of the packet transmitter
// assumes it is bound onto every meter_packet_tx
`timescale 1ns/10ps
`default_nettype none
module meter_packet_tx_chk #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic serial_tx_out,
	input wire logic energy_pulse_out,
	input wire logic modulator_sample_clk,
	input wire logic filter_word_rate,
	input wire logic [15:0] pulse_count
);
	// ----
	// run counters
	// ----
	logic [31:0] lo_q;
	logic [31:0] hi_q;
	logic [6:0] wr_q;
	logic seen_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// run lengths, since bit times exceed any legal repetition count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lo_q <= 32'h0;
			hi_q <= 32'h0;
			wr_q <= 7'h0;
			seen_q <= 1'b0;
		end else begin
			lo_q <= serial_tx_out ? 32'h0 : lo_q + 32'h1;
			hi_q <= serial_tx_out ? hi_q + 32'h1 : 32'h0;
			wr_q <= filter_word_rate ? 7'h0 : wr_q + 7'h1;
			seen_q <= seen_q | filter_word_rate;
		end
	end
	AST_SAMPLE_DIV: assert property ($rose(modulator_sample_clk) |=> modulator_sample_clk
		##1 !modulator_sample_clk [*2] ##1 modulator_sample_clk) else $error("sample clock not clk/4");
	AST_WORD_RATE: assert property (seen_q |-> filter_word_rate == (wr_q == 7'h7F))
		else $error("word strobe not every 128 clocks");
	AST_IDLE_HIGH: assert property ($rose(nrst) |-> serial_tx_out && !energy_pulse_out)
		else $error("outputs not idle after reset");
	AST_BIT_TIME: assert property ($rose(serial_tx_out) |-> lo_q % BIT_CYCLES == 0)
		else $error("low run not whole bit times");
	AST_LOW_MAX: assert property ($rose(serial_tx_out) |-> lo_q <= 10 * BIT_CYCLES)
		else $error("low run longer than a character");
	AST_STOP_HIGH: assert property ($fell(serial_tx_out) |-> hi_q >= BIT_CYCLES)
		else $error("start without a full stop bit");
	AST_PULSE_STEP: assert property ($changed(pulse_count) |-> pulse_count == $past(pulse_count) + 16'h0001)
		else $error("pulse count step not one");
	AST_PULSE_RISE: assert property ($changed(pulse_count) |-> energy_pulse_out && !$past(energy_pulse_out))
		else $error("pulse count moved without a pulse");
endmodule : meter_packet_tx_chk
bind meter_packet_tx meter_packet_tx_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
	.serial_tx_out(serial_tx_out), .energy_pulse_out(energy_pulse_out),
	.modulator_sample_clk(modulator_sample_clk), .filter_word_rate(filter_word_rate), .pulse_count(pulse_count));
`default_nettype wire

// file: test/meter_packet_tx_test.sv
// self-checking bench of the packet transmitter
// assumes the host model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module meter_packet_tx_test;
	// ----
	// stimulus and checks
	// ----
	localparam int BIT = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic rx_q = 1'b1;
	logic wiggle = 1'b0;
	logic calibrated = 1'b0;
	meter_pkg::fault_type faults = 4'h0;
	meter_pkg::meas_type meas = {24'h123456, 24'h00ABCD, 24'h654321, 24'h0F0E0D, 24'h111111, 24'h2468AC, 8'hC3};
	logic tx;
	logic rx_valid;
	logic rx_err;
	logic [7:0] rx_byte;
	logic [7:0] pkt [24];
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	logic [15:0] chan_v = 16'h0000;
	logic pulse;
	logic [15:0] hp_v1;
	logic [15:0] hp_v2;
	logic [15:0] pulse_cnt;
	// short accumulator so pulses come within a thousand clocks
	meter_packet_tx #(.BIT_CYCLES(BIT), .ACC_BITS(36)) u_dut (.clk(clk), .nrst(nrst), .serial_rx_in(rx_q),
		.calibrated(calibrated), .faults(faults), .meas(meas), .chan_v1(chan_v), .chan_v2(chan_v),
		.pulse_half_period(8'h02), .serial_tx_out(tx), .energy_pulse_out(pulse), .modulator_sample_clk(),
		.filter_word_rate(), .chan_v1_hp(hp_v1), .chan_v2_hp(hp_v2), .pulse_count(pulse_cnt));
	host_uart_rx #(.BIT_CYCLES(BIT)) u_host (.clk(clk), .nrst(nrst), .line(tx), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_err(rx_err));
	always #20 clk = ~clk;
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	// pulled-up receive pin, toggled only to prove it is ignored
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rx_q <= wiggle ? ~rx_q : 1'b1;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic restart;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
	endtask : restart
	task automatic get_pkt;
		int w;
		for (int i = 0; i < 24; i++) begin
			w = 0;
			@(posedge clk);
			while (rx_valid !== 1'b1 && w < 400) begin
				@(posedge clk);
				w++;
			end
			pkt[i] = rx_byte;
			check({7'h0, rx_err}, 8'h00);
			check({7'h0, rx_valid}, 8'h01);
		end
	endtask : get_pkt
	task automatic judge(input logic [7:0] hdr);
		logic [191:0] e;
		logic [7:0] sum;
		e = {hdr, 8'h5A, calibrated ? meas.volt_coef : 24'hFFFFFF, meas.volt_cycle,
			calibrated ? meas.curr_coef : 24'hFFFFFF, meas.curr_cycle,
			calibrated ? meas.pwr_coef : 24'hFFFFFF, meas.pwr_cycle, meas.flag, 16'h0000, 8'h00};
		sum = 8'h00;
		for (int i = 2; i < 23; i++) sum += e[191 - 8 * i -: 8];
		check(pkt[0], hdr);
		check(pkt[1], 8'h5A);
		for (int i = 2; i < 23; i++) check(pkt[i], e[191 - 8 * i -: 8]);
		check(pkt[23], sum);
	endtask : judge
	task automatic pulse_run;
		int w;
		int hi;
		int lo;
		chan_v <= 16'h4000;
		restart();
		w = 0;
		hi = 0;
		lo = 0;
		@(negedge clk);
		while (pulse !== 1'b1 && w < 4000) begin
			@(negedge clk);
			w++;
		end
		check(pulse_cnt[7:0], 8'h01);
		while (pulse === 1'b1 && hi < 4000) begin
			@(negedge clk);
			hi++;
		end
		while (pulse === 1'b0 && lo < 4000) begin
			@(negedge clk);
			lo++;
		end
		check({7'h0, hi == lo}, 8'h01);
		check(pulse_cnt[7:0], 8'h02);
		check(pulse_cnt[15:8], 8'h00);
		check({7'h0, hp_v1 < 16'h4000}, 8'h01);
		check({7'h0, hp_v2 < 16'h4000}, 8'h01);
		$display("test pulses done");
	endtask : pulse_run
	initial begin
		calibrated <= 1'b0;
		wiggle <= 1'b1;
		restart();
		get_pkt();
		judge(8'hAA);
		check(pkt[14], 8'hFF);
		wiggle <= 1'b0;
		$display("test uncalibrated done");
		calibrated <= 1'b1;
		restart();
		get_pkt();
		judge(8'h55);
		get_pkt();
		judge(8'h55);
		$display("test calibrated done");
		for (int i = 0; i < 4; i++) begin
			faults <= 4'h1 << i;
			restart();
			get_pkt();
			judge({4'hF, 4'h1 << i});
		end
		$display("test faults done");
		pulse_run();
		wrap_up();
	end
endmodule : meter_packet_tx_test
`default_nettype wire
